// ==== rtl/pcm_amp_mode_control.v ====
// Purpose: Mode, channel and filter control for a PCM input speaker amplifier.
// Assumes: Bit clock, word clock and data are sampled by the 10 MHz core clock.
// Notes:   Word clock low marks the left word; a short high pulse marks a TDM frame.
`include "pcm_amp_defines.vh"
`default_nettype none
module pcm_amp_mode_control #(
    parameter WORD_W     = `WORD_BITS,
    parameter IDLE_LIMIT = `IDLE_CYCLES
) (
    input  wire              core_clk,
    input  wire              reset_n,
    input  wire              bitClk,
    input  wire              wordClk,
    input  wire              serialData,
    input  wire [1:0]        channel_shutdown_select,
    output reg  [WORD_W-1:0] sampleData,
    output wire              sampleValid,
    input  wire              sampleReady,
    output reg  [1:0]        filterSel,
    output reg               outputEnable,
    output reg               standby,
    output reg               shutdown
);
    // =====================================================================
    // Input synchronisers
    // =====================================================================
    reg [1:0] bclkSync_r;
    reg [1:0] wclkSync_r;
    reg [1:0] dataSync_r;
    reg [1:0] selSync0_r;
    reg [1:0] selSync1_r;
    reg       bclkPrev_r;
    reg       wclkPrev_r;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bclkSync_r <= 2'h0;
            // Word clock idles high before the first stream, so a low reset value would show a false rise.
            wclkSync_r <= 2'h3;
            dataSync_r <= 2'h0;
            selSync0_r <= 2'h0;
            selSync1_r <= 2'h0;
            bclkPrev_r <= 1'b0;
            wclkPrev_r <= 1'b1;
        end else begin
            bclkSync_r <= {bclkSync_r[0], bitClk};
            wclkSync_r <= {wclkSync_r[0], wordClk};
            dataSync_r <= {dataSync_r[0], serialData};
            selSync0_r <= channel_shutdown_select;
            selSync1_r <= selSync0_r;
            bclkPrev_r <= bclkSync_r[1];
            wclkPrev_r <= wclkSync_r[1];
        end
    end
    wire bclkRise = bclkSync_r[1] && !bclkPrev_r;
    wire wclkRise = wclkSync_r[1] && !wclkPrev_r;
    wire wclkFall = !wclkSync_r[1] && wclkPrev_r;
    wire [1:0] band = selSync1_r;

    // =====================================================================
    // Standby detection
    // =====================================================================
    reg [`CNT_W-1:0] idleCnt_r;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idleCnt_r <= {`CNT_W{1'b0}};
            standby   <= 1'b1;
        end else if (bclkRise) begin
            idleCnt_r <= {`CNT_W{1'b0}};
            standby   <= 1'b0;                                  // [RULE15]
        end else if (idleCnt_r >= IDLE_LIMIT[`CNT_W-1:0]) begin
            standby   <= 1'b1;                                  // [RULE1]
        end else begin
            idleCnt_r <= idleCnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // =====================================================================
    // Mode and output stage control
    // =====================================================================
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shutdown     <= 1'b1;
            outputEnable <= 1'b0;
        end else begin
            shutdown     <= (band == `BAND_SHUTDOWN);           // [RULE8]
            // Output stage is released only when neither low-power state holds.
            outputEnable <= (band != `BAND_SHUTDOWN) && !standby; // [RULE2] [RULE9]
        end
    end

    // =====================================================================
    // Sample rate measurement and filter choice
    // =====================================================================
    reg [`CNT_W-1:0] rateCnt_r;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rateCnt_r <= {`CNT_W{1'b0}};
            filterSel <= `FILT_VOICE;
        end else if (wclkRise) begin
            rateCnt_r <= {`CNT_W{1'b0}};
            // Period is compared, so a longer period means a lower rate.
            if (rateCnt_r > `RATE_30K_CYC)
                filterSel <= `FILT_VOICE;                       // [RULE4] [RULE5]
            else if (rateCnt_r > `RATE_50K_CYC)
                filterSel <= `FILT_MUSIC;                       // [RULE6]
            else
                filterSel <= `FILT_HIGH;                        // [RULE7]
        end else if (rateCnt_r != {`CNT_W{1'b1}}) begin
            rateCnt_r <= rateCnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // =====================================================================
    // Serial word capture
    // =====================================================================
    // Bit count restarts at every word clock edge of a half-duty frame. A fall that
    // comes within one bit of the rise is a TDM frame pulse: counting runs on, and
    // the second slot is the sixteen bits after the first.
    reg [6:0]        bitCnt_r;
    reg [WORD_W-1:0] shift_r;
    reg              isRight_r;
    reg              tdm_r;
    reg              wordDone_r;
    reg              wordRight_r;
    reg [WORD_W-1:0] wordOut_r;
    wire [WORD_W-1:0] shifted  = {shift_r[WORD_W-2:0], dataSync_r[1]};
    wire              slot1End = (bitCnt_r == `SLOT1_LAST);
    wire              slot2End = tdm_r && (bitCnt_r == `SLOT2_LAST);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // A saturated count keeps the first fall after reset from looking like a pulse.
            bitCnt_r    <= `BITCNT_MAX;
            shift_r     <= {WORD_W{1'b0}};
            isRight_r   <= 1'b0;
            tdm_r       <= 1'b0;
            wordDone_r  <= 1'b0;
            wordRight_r <= 1'b0;
            wordOut_r   <= {WORD_W{1'b0}};
        end else begin
            wordDone_r <= 1'b0;
            if (wclkFall) begin
                if (bitCnt_r > `TDM_PULSE_MAX) begin
                    bitCnt_r  <= 7'h00;
                    isRight_r <= 1'b0;
                    tdm_r     <= 1'b0;
                end else begin
                    tdm_r     <= 1'b1;                          // [RULE14]
                end
            end else if (wclkRise) begin
                bitCnt_r  <= 7'h00;
                isRight_r <= 1'b1;
            end else if (bclkRise) begin
                shift_r  <= shifted;
                bitCnt_r <= (bitCnt_r == `BITCNT_MAX) ? bitCnt_r : bitCnt_r + 7'h01;
                // Bits past the last slot in use are ignored.
                if (slot1End || slot2End) begin
                    wordDone_r  <= 1'b1;                        // [RULE14]
                    wordRight_r <= tdm_r ? slot2End : isRight_r;
                    wordOut_r   <= shifted;
                end
            end
        end
    end

    // =====================================================================
    // Channel selection into the output buffer
    // =====================================================================
    reg              pushValid_r;
    reg [WORD_W-1:0] pushData_r;
    reg [WORD_W-1:0] leftWord_r;
    wire             pushReady;
    wire [WORD_W:0]  sumLR = {leftWord_r[WORD_W-1], leftWord_r} + {wordOut_r[WORD_W-1], wordOut_r};
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pushValid_r  <= 1'b0;
            pushData_r   <= {WORD_W{1'b0}};
            leftWord_r   <= {WORD_W{1'b0}};
        end else begin
            if (pushValid_r && pushReady)
                pushValid_r <= 1'b0;
            if (wordDone_r) begin
                if (!wordRight_r)
                    leftWord_r <= wordOut_r;
                if (outputEnable) begin
                    case (band)
                    `BAND_LEFT: begin
                        if (!wordRight_r) begin
                            pushValid_r <= 1'b1;
                            pushData_r  <= wordOut_r;           // [RULE10]
                        end
                    end
                    `BAND_RIGHT: begin
                        if (wordRight_r) begin
                            pushValid_r <= 1'b1;
                            pushData_r  <= wordOut_r;           // [RULE11]
                        end
                    end
                    `BAND_AVERAGE: begin
                        if (wordRight_r) begin
                            pushValid_r <= 1'b1;
                            pushData_r  <= sumLR[WORD_W:1];     // [RULE12]
                        end
                    end
                    default: begin
                        pushValid_r <= 1'b0;
                    end
                    endcase
                end
            end
        end
    end

    wire [WORD_W-1:0] bufData;
    pair_buffer #(
        .WIDTH   (WORD_W)
    ) u_buf (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .inValid  (pushValid_r),
        .inReady  (pushReady),
        .inData   (pushData_r),
        .outValid (sampleValid),
        .outReady (sampleReady),
        .outData  (bufData)
    );
    always @* begin
        sampleData = bufData;
    end
endmodule
`default_nettype wire

// ==== include/pcm_amp_defines.vh ====
// Purpose: Shared constants for the amplifier mode and channel control block.
// Assumes: Core clock of 10 MHz; 16-bit audio words.
// Notes:   Band codes come from an external four-level comparator on the select line.
// How it works
// RULE1 - Bit clock that stops toggling is detected and standby entered automatically.
// RULE2 - In standby the output stage is off and both outputs are high impedance.
// RULE3 - Controller should prefer shutdown over stopping the bit clock for low power.
// RULE4 - Filter setting is chosen from the measured word clock rate, no config input.
// RULE5 - Below 30 kHz the voice filter setting is chosen.
// RULE6 - Between 30 kHz and 50 kHz the first music filter setting is chosen.
// RULE7 - Above 50 kHz the high-rate music filter setting is chosen.
// RULE8 - Select line below the lowest band puts the device into shutdown.
// RULE9 - Shutdown turns every block off and forces the output stage to high impedance; here capture and rate measurement still run.
// RULE10 - Select line above the upper band plays only the left word.
// RULE11 - Select line between upper and middle bands plays only the right word.
// RULE12 - Select line between middle and lowest bands plays left plus right halved.
// RULE13 - Source supplies 32, 48 or 64 bit clocks per word clock period.
// RULE14 - In TDM, left uses slot one; right or average uses slot two.
// RULE15 - When bit clock resumes after standby, playback of the selected channel returns.
`ifndef PCM_AMP_DEFINES_VH
`define PCM_AMP_DEFINES_VH
`define BAND_SHUTDOWN   2'h0
`define BAND_AVERAGE    2'h1
`define BAND_RIGHT      2'h2
`define BAND_LEFT       2'h3
`define FILT_VOICE      2'h0
`define FILT_MUSIC      2'h1
`define FILT_HIGH       2'h2
`define CORE_HZ         10000000
`define IDLE_TIME_US    20
`define IDLE_CYCLES     ((`IDLE_TIME_US * (`CORE_HZ / 1000000)))
`define RATE_30K_CYC    (`CORE_HZ / 30000)
`define RATE_50K_CYC    (`CORE_HZ / 50000)
`define WORD_BITS       16
`define CNT_W           16
`define SLOT1_LAST      7'h0F
`define SLOT2_LAST      7'h1F
`define BITCNT_MAX      7'h7F
`define TDM_PULSE_MAX   7'h01
`endif

// ==== rtl/pair_buffer.v ====
// Purpose: Two-entry valid/ready buffer for output samples.
// Assumes: Single clock domain.
// Notes:   Full only after two words, so a stall loses nothing.
`default_nettype none
module pair_buffer #(
    parameter WIDTH = 16
) (
    input  wire             core_clk,
    input  wire             reset_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg             wrPtr_r;
    reg             rdPtr_r;
    reg [1:0]       count_r;
    wire            doWrite = inValid && inReady;
    wire            doRead  = outValid && outReady;
    assign inReady  = (count_r != 2'h2);
    assign outValid = (count_r != 2'h0);
    assign outData  = mem_r[rdPtr_r];
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r    <= 1'b0;
            rdPtr_r    <= 1'b0;
            count_r    <= 2'h0;
            mem_r[0]   <= {WIDTH{1'b0}};
            mem_r[1]   <= {WIDTH{1'b0}};
        end else begin
            if (doWrite) begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r        <= ~wrPtr_r;
            end
            if (doRead)
                rdPtr_r <= ~rdPtr_r;
            if (doWrite && !doRead)
                count_r <= count_r + 2'h1;
            else if (doRead && !doWrite)
                count_r <= count_r - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/pcm_amp_mode_control_asserts.sv ====
// Purpose: Port level checks for the amplifier mode control block.
// Assumes: One core clock domain with an active low asynchronous reset.
// Notes:   Bit clock synchronising lag is allowed for in the fixed margins.
`include "pcm_amp_defines.vh"
`default_nettype none
// ====
// Checker
module pcm_amp_mode_control_asserts #(
    parameter WORD_W     = 16,
    parameter IDLE_LIMIT = 200
) (
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              bitClk,
    input wire logic              wordClk,
    input wire logic              serialData,
    input wire logic [1:0]        channel_shutdown_select,
    input wire logic [WORD_W-1:0] sampleData,
    input wire logic              sampleValid,
    input wire logic              sampleReady,
    input wire logic [1:0]        filterSel,
    input wire logic              outputEnable,
    input wire logic              standby,
    input wire logic              shutdown
);
    logic       lastClk;
    logic [9:0] idleCnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Saturating count of core cycles since the bit clock last moved.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lastClk <= 1'b0;
            idleCnt <= 10'h000;
        end else begin
            lastClk <= bitClk;
            idleCnt <= (bitClk != lastClk) ? 10'h000 : idleCnt + {9'h000, idleCnt != 10'h3FF};
        end
    end
    AST_IDLE_STBY: assert property (idleCnt == IDLE_LIMIT + 6 |-> standby)
        else $error("standby not entered after bit clock stopped");
    AST_WAKE: assert property ($rose(bitClk) |-> ##[1:4] !standby)
        else $error("standby kept while bit clock toggles");
    AST_STBY_OFF: assert property (standby [*2] |-> !outputEnable)
        else $error("output driven in standby");
    AST_SHDN_OFF: assert property (shutdown [*2] |-> !outputEnable)
        else $error("output driven in shutdown");
    AST_OE_ON: assert property ((!standby && !shutdown) [*3] |-> outputEnable)
        else $error("output not driven while playing");
    AST_BAND_SHDN: assert property ((channel_shutdown_select == `BAND_SHUTDOWN) [*4] |=> shutdown)
        else $error("lowest band did not shut down");
    AST_BAND_RUN: assert property ((channel_shutdown_select != `BAND_SHUTDOWN) [*4] |=> !shutdown)
        else $error("shutdown without lowest band");
    AST_HOLD: assert property (sampleValid && !sampleReady |=> sampleValid && $stable(sampleData))
        else $error("stalled sample lost or changed");
    AST_FILT: assert property (filterSel != 2'h3)
        else $error("undefined filter setting");
    cover property (sampleValid && sampleReady);
    cover property (sampleValid && !sampleReady);
    cover property ($rose(standby));
    cover property (shutdown && !standby);
endmodule
bind pcm_amp_mode_control pcm_amp_mode_control_asserts #(.WORD_W(WORD_W), .IDLE_LIMIT(IDLE_LIMIT)) chk (
    .core_clk(core_clk), .reset_n(reset_n), .bitClk(bitClk), .wordClk(wordClk), .serialData(serialData),
    .channel_shutdown_select(channel_shutdown_select), .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .filterSel(filterSel), .outputEnable(outputEnable), .standby(standby),
    .shutdown(shutdown));
`default_nettype wire

// ==== verification/pcm_source_model.sv ====
// Purpose: Audio source that drives bit clock, word clock and serial data.
// Assumes: Word clock low carries the left word, data MSB first.
// Notes:   Clocks stand still between streams so standby can be reached.
`default_nettype none
// ====
// Source
module pcm_source_model (
    output var logic bitClk,
    output var logic wordClk,
    output var logic serialData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bitClk = 1'b0;
        wordClk = 1'b1;
        serialData = 1'b0;
    end
    // Odd start offset keeps every link edge away from core clock edges.
    task automatic stream(input logic [15:0] l[5], input logic [15:0] r[5], input int bits, input bit tdm);
        int f, i, h;
        h = bits / 2;
        #37;
        for (f = 0; f < 5; f++) begin
            for (i = 0; i < bits; i++) begin
                // A one-bit pulse opens a TDM frame; otherwise the word clock has half duty.
                wordClk = tdm ? (i == 0) : (i >= h);
                // Bits past the word toggle, so a slot misread cannot pass.
                if (tdm)
                    serialData = i < 16 ? l[f][15 - i] : (i < 32 ? r[f][31 - i] : ~serialData);
                else
                    serialData = (i % h) >= 16 ? ~serialData : (i < h ? l[f][15 - i % h] : r[f][15 - i % h]);
                #400 bitClk = 1'b1;
                #400 bitClk = 1'b0;
            end
        end
        serialData = ~serialData;
    endtask
    // Shutdown, not a stopped clock, is the low power request.
endmodule
`default_nettype wire

// ==== verification/pcm_amp_mode_control_test.sv ====
// Purpose: Self-checking bench for the amplifier mode control block.
// Assumes: 10 MHz core clock, 800 ns bit clock from the source model.
// Notes:   The first frame of each stream is a warm-up and is not checked.
`include "pcm_amp_defines.vh"
`default_nettype none
// ====
// Bench
module pcm_amp_mode_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, reset_n, bitClk, wordClk, serialData, sampleReady;
    logic        sampleValid, outputEnable, standby, shutdown;
    logic [1:0]  channel_shutdown_select, filterSel, band;
    logic [15:0] sampleData, lw[5], rw[5];
    logic [15:0] got[$];
    int          errors, samples_checked, cycles, seed, k, i, bits;
    pcm_amp_mode_control #(.IDLE_LIMIT(50)) uut (.core_clk(core_clk), .reset_n(reset_n), .bitClk(bitClk),
        .wordClk(wordClk), .serialData(serialData), .channel_shutdown_select(channel_shutdown_select),
        .sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady), .filterSel(filterSel),
        .outputEnable(outputEnable), .standby(standby), .shutdown(shutdown));
    pcm_source_model src (.bitClk(bitClk), .wordClk(wordClk), .serialData(serialData));
    function automatic logic [15:0] pick(input logic [1:0] b, input logic [15:0] l, input logic [15:0] r);
        logic [16:0] s;
        s = {l[15], l} + {r[15], r};
        case (b)
            `BAND_LEFT: pick = l;
            `BAND_RIGHT: pick = r;
            default: pick = s[16:1];
        endcase
    endfunction
    task check(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task results;
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Random stalls on the receiving side exercise the two-entry buffer.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (sampleValid === 1'b1 && sampleReady === 1'b1) got.push_back(sampleData);
        sampleReady <= 1'($random(seed));
        if (cycles > 40000) begin
            errors++;
            results();
        end
    end
    initial begin
        seed = 34782;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        reset_n = 1'b0;
        sampleReady = 1'b0;
        channel_shutdown_select = `BAND_LEFT;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            band = 2'h3 - k[1:0];
            bits = 32 + 16 * (k % 3);
            @(posedge core_clk);
            channel_shutdown_select <= band;
            for (i = 0; i < 5; i++) begin
                lw[i] = 16'($random(seed));
                rw[i] = 16'($random(seed));
            end
            lw[1] = 16'h7FFF;
            rw[1] = 16'h7FFF;
            lw[2] = 16'h8000;
            rw[2] = 16'h8001;
            repeat (10) @(posedge core_clk);
            fork
                src.stream(lw, rw, bits, k >= 4);
                begin
                    repeat (bits * 8 + 20) @(posedge core_clk);
                    @(negedge core_clk);
                    got.delete();
                    check("standby", 16'h0, standby);
                    check("shutdown", {15'h0, band == 2'h0}, shutdown);
                    check("outputEnable", {15'h0, band != 2'h0}, outputEnable);
                end
            join
            repeat (20) @(posedge core_clk);
            @(negedge core_clk);
            if (band != 2'h0) check("filterSel", bits == 32 ? 16'h1 : 16'h0, filterSel);
            check("count", band == 2'h0 ? 16'h0 : 16'h4, 16'(got.size()));
            for (i = 1; i < 5 && i <= got.size() && band != 2'h0; i++)
                check("sample", pick(band, lw[i], rw[i]), got[i - 1]);
            repeat (80) @(posedge core_clk);
            @(negedge core_clk);
            check("standby", 16'h1, standby);
            check("outputEnable", 16'h0, outputEnable);
        end
        results();
    end
endmodule
`default_nettype wire
